// >>> upd_params.svh
// Purpose: Constants of the USB/PS2 detect and line control block.
// Assumes: 125 MHz system clock; register bus with 8-bit byte address.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`ifndef UPD_PARAMS_SVH
`define UPD_PARAMS_SVH

// Clock rate and documented times.
`define UPD_CLK_KHZ        125000
`define UPD_T_POWER_MS     350
`define UPD_T_PS2_SEL_MS   1
`define UPD_T_PS2_HALF_US  40

// Cycle counts derived from the times above.
`define UPD_POWER_CYC  (`UPD_T_POWER_MS * `UPD_CLK_KHZ)
`define UPD_SEL_CYC    (`UPD_T_PS2_SEL_MS * `UPD_CLK_KHZ)
`define UPD_HALF_CYC   ((`UPD_T_PS2_HALF_US * `UPD_CLK_KHZ) / 1000)

// Frame layout: start, eight data bits, odd parity, stop.
`define UPD_FRAME_BITS 4'hb
`define UPD_DATA_BITS  8

// Register byte addresses.
`define UPD_ADDR_CTRL   8'h00
`define UPD_ADDR_TXDATA 8'h04
`define UPD_ADDR_RXDATA 8'h08
`define UPD_ADDR_STATUS 8'h0c
`define UPD_ADDR_IRQST  8'h10
`define UPD_ADDR_IRQMSK 8'h14

// Interrupt status bit positions.
`define UPD_EV_DFALL  0
`define UPD_EV_TXDONE 1
`define UPD_EV_RXDONE 2
`define UPD_EV_ABORT  3
`define UPD_EV_MODE   4

// Reset values.
`define UPD_MASK_RST  5'h00
`define UPD_CTRL_RST  1'b0

`endif

// >>> upd_pkg.sv
// Purpose: Types of the USB/PS2 detect and line control block.
// Assumes: Constants come from upd_params.svh.
// Notes:   The whole module state is one packed struct.
package upd_pkg;

  // Block state, one-hot.
  typedef enum logic [5:0] {
    ST_POWER_WAIT = 6'h01,
    ST_DETECT     = 6'h02,
    ST_USB        = 6'h04,
    ST_PS2_IDLE   = 6'h08,
    ST_PS2_TX     = 6'h10,
    ST_PS2_RX     = 6'h20
  } upd_state_e;

  typedef struct packed {
    upd_state_e  fsm;
    logic [25:0] cnt;
    logic        ph;
    logic [3:0]  bitn;
    logic [10:0] shf;
    logic        dp_s1;
    logic        dp_s2;
    logic        dp_q;
    logic        dm_s1;
    logic        dm_s2;
    logic        dm_q;
    logic        irq_en;
    logic        tx_req;
    logic [7:0]  tx_byte;
    logic [7:0]  rx_data;
    logic        rx_err;
    logic [4:0]  stat;
    logic [4:0]  mask;
    logic [31:0] rdata;
    logic        irq;
    logic        ck_dir;
    logic        dt_dir;
    logic        usb_on;
    logic        ps2_on;
  } upd_regs_s;

endpackage

// >>> upd_line_ctrl.sv
// Purpose: Decides USB or PS2 use of the shared pin pair and runs PS2 lines.
// Assumes: Pins are sampled by sys_clk; the USB engine flags SETUP tokens.
// Notes:   Open-drain pins are driven low only; high comes from pull-ups.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/10ps
`include "upd_params.svh"

// Operation
// - After reset wait 350 ms before enabling the USB engine and pull-up.
// - While undetermined the pins act as USB data with 1.5K pull-up on D-.
// - A positive data line high for 1 ms without a break selects PS2.
// - A valid SETUP token during detection selects USB.
// - Once decided, exactly one mode runs and it never changes.
// - The USB positive and negative pins are the PS2 clock and data.
// - In PS2 mode both pins are open-drain with 5K pull-ups enabled.
// - A PS2 frame is start, eight data, odd parity and stop bits.
// - The device makes the PS2 clock, about 80 us per period.
// - A line is released high by direction input with pull-up on.
// - A line is driven low by direction output with value zero.
// - In PS2 mode output values stay zero and pull-ups stay one.
// - With its enable set, a data line falling edge raises interrupt.
// - A clock line found low after release aborts the transfer.
module upd_line_ctrl
  import upd_pkg::*;
#(
  parameter int POWER_CYC = `UPD_POWER_CYC,
  parameter int SEL_CYC   = `UPD_SEL_CYC,
  parameter int HALF_CYC  = `UPD_HALF_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        setup_token_valid,
  input  wire logic        shared_clock_pin_in,
  output logic             shared_clock_pin_out,
  output logic             shared_clock_pin_oe_n,
  input  wire logic        shared_data_pin_in,
  output logic             shared_data_pin_out,
  output logic             shared_data_pin_oe_n,
  output logic             clock_pin_pullup_enable,
  output logic             data_pin_pullup_enable,
  output logic             usb_pullup_enable,
  output logic             usb_engine_enable,
  output logic             mode_usb,
  output logic             mode_ps2,
  output logic             keyboard_pin_interrupt
);

  localparam logic [25:0] POWER_LAST = 26'(POWER_CYC - 1);
  localparam logic [25:0] SEL_LAST   = 26'(SEL_CYC - 1);
  localparam logic [25:0] HALF_LAST  = 26'(HALF_CYC - 1);

  upd_regs_s r_reg;
  upd_regs_s r_next;

  // Next-state logic; every update is frozen while the clock enable is low.
  always_comb begin
    logic       dm_fall;
    logic       half_end;
    logic [4:0] ev;
    logic [4:0] clr;
    dm_fall  = r_reg.dm_q & ~r_reg.dm_s2;
    half_end = (r_reg.cnt == HALF_LAST);
    ev       = 5'h00;
    clr      = 5'h00;
    r_next   = r_reg;
    if (clk_en) begin
      // Two flip-flops per pin, then a third stage for edge finding.
      r_next.dp_s1 = shared_clock_pin_in;
      r_next.dp_s2 = r_reg.dp_s1;
      r_next.dp_q  = r_reg.dp_s2;
      r_next.dm_s1 = shared_data_pin_in;
      r_next.dm_s2 = r_reg.dm_s1;
      r_next.dm_q  = r_reg.dm_s2;
      r_next.cnt   = r_reg.cnt + 26'h1;
      case (r_reg.fsm)
        ST_POWER_WAIT: begin
          if (r_reg.cnt == POWER_LAST) begin
            r_next.fsm = ST_DETECT;
            r_next.cnt = 26'h0;
          end
        end
        ST_DETECT: begin
          // Bit stuffing keeps a USB host from holding D+ high this long.
          if (!r_reg.dp_s2) begin
            r_next.cnt = 26'h0;
          end
          if (setup_token_valid) begin
            r_next.fsm   = ST_USB;
            ev[`UPD_EV_MODE] = 1'b1;
          end else if (r_reg.dp_s2 && r_reg.cnt == SEL_LAST) begin
            r_next.fsm   = ST_PS2_IDLE;
            ev[`UPD_EV_MODE] = 1'b1;
          end
        end
        ST_USB: begin
          r_next.cnt = 26'h0;
        end
        ST_PS2_IDLE: begin
          r_next.cnt    = 26'h0;
          r_next.ck_dir = 1'b0;
          r_next.dt_dir = 1'b0;
          if (dm_fall && r_reg.dp_s2) begin
            // Host start bit: clock the frame in, first half clock low.
            r_next.fsm    = ST_PS2_RX;
            r_next.ph     = 1'b1;
            r_next.bitn   = 4'h0;
            r_next.ck_dir = 1'b1;
          end else if (r_reg.tx_req && r_reg.dp_s2 && r_reg.dm_s2) begin
            // Load stop, parity, data and start, sent from bit 0 up.
            r_next.fsm    = ST_PS2_TX;
            r_next.shf    = {1'b1, ~^r_reg.tx_byte, r_reg.tx_byte, 1'b0};
            r_next.dt_dir = 1'b1;
            r_next.ph     = 1'b0;
            r_next.bitn   = 4'h0;
            r_next.tx_req = 1'b0;
          end
        end
        ST_PS2_TX: begin
          if (half_end) begin
            r_next.cnt = 26'h0;
            if (!r_reg.ph) begin
              if (!r_reg.dp_s2) begin
                r_next.fsm    = ST_PS2_IDLE;
                r_next.dt_dir = 1'b0;
                ev[`UPD_EV_ABORT] = 1'b1;
              end else begin
                r_next.ph     = 1'b1;
                r_next.ck_dir = 1'b1;
              end
            end else begin
              r_next.ph     = 1'b0;
              r_next.ck_dir = 1'b0;
              r_next.shf    = {1'b0, r_reg.shf[10:1]};
              r_next.bitn   = r_reg.bitn + 4'h1;
              r_next.dt_dir = ~r_reg.shf[1];
              if (r_reg.bitn == `UPD_FRAME_BITS - 4'h1) begin
                r_next.fsm    = ST_PS2_IDLE;
                r_next.dt_dir = 1'b0;
                ev[`UPD_EV_TXDONE] = 1'b1;
              end
            end
          end
        end
        ST_PS2_RX: begin
          if (half_end) begin
            r_next.cnt = 26'h0;
            if (r_reg.ph) begin
              r_next.ph     = 1'b0;
              r_next.ck_dir = 1'b0;
              if (r_reg.bitn == 4'ha) begin
                // Acknowledge pulse done: release both lines.
                r_next.fsm     = ST_PS2_IDLE;
                r_next.dt_dir  = 1'b0;
                r_next.rx_data = r_reg.shf[8:1];
                r_next.rx_err  = ~r_reg.shf[10] | ~(^r_reg.shf[9:1]);
                ev[`UPD_EV_RXDONE] = 1'b1;
              end
            end else if (!r_reg.dp_s2) begin
              r_next.fsm    = ST_PS2_IDLE;
              r_next.dt_dir = 1'b0;
              ev[`UPD_EV_ABORT] = 1'b1;
            end else begin
              // Sample while clock is high, then pull it low again.
              r_next.shf    = {r_reg.dm_s2, r_reg.shf[10:1]};
              r_next.bitn   = r_reg.bitn + 4'h1;
              r_next.ph     = 1'b1;
              r_next.ck_dir = 1'b1;
              if (r_reg.bitn == 4'h9) begin
                r_next.dt_dir = 1'b1;
              end
            end
          end
        end
        default: begin
          r_next.fsm = ST_POWER_WAIT;
        end
      endcase
      // Enables are decoded ahead of the register so each output is a flop.
      r_next.usb_on = r_next.fsm[1] | r_next.fsm[2];
      r_next.ps2_on = r_next.fsm[3] | r_next.fsm[4] | r_next.fsm[5];
      // Data line falling edge, armed by the enable bit.
      if (r_reg.irq_en && dm_fall && r_reg.fsm[3] | r_reg.fsm[4] |
          r_reg.fsm[5]) begin
        ev[`UPD_EV_DFALL] = 1'b1;
      end
      // Register writes; a transmit byte is taken only when none is pending.
      if (wr) begin
        case (addr)
          `UPD_ADDR_CTRL:   r_next.irq_en = wdata[0];
          `UPD_ADDR_TXDATA: begin
            if (!r_reg.tx_req) begin
              r_next.tx_req  = 1'b1;
              r_next.tx_byte = wdata[7:0];
            end
          end
          `UPD_ADDR_IRQST:  clr = wdata[4:0];
          `UPD_ADDR_IRQMSK: r_next.mask = wdata[4:0];
          default:          r_next.irq_en = r_reg.irq_en;
        endcase
      end
      // Read data stand for one cycle only; unmapped reads return zero.
      r_next.rdata = 32'h0;
      if (rd) begin
        case (addr)
          `UPD_ADDR_CTRL:   r_next.rdata = {31'h0, r_reg.irq_en};
          `UPD_ADDR_TXDATA: r_next.rdata = {23'h0, r_reg.tx_req,
                                            r_reg.tx_byte};
          `UPD_ADDR_RXDATA: r_next.rdata = {23'h0, r_reg.rx_err,
                                            r_reg.rx_data};
          `UPD_ADDR_STATUS: r_next.rdata = {26'h0, r_reg.fsm};
          `UPD_ADDR_IRQST:  r_next.rdata = {27'h0, r_reg.stat};
          `UPD_ADDR_IRQMSK: r_next.rdata = {27'h0, r_reg.mask};
          default:          r_next.rdata = 32'h0;
        endcase
      end
      // A new event beats a clear in the same cycle.
      r_next.stat = (r_reg.stat & ~clr) | ev;
      r_next.irq  = |(r_next.stat & r_next.mask);
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      r_reg        <= '0;
      r_reg.fsm    <= ST_POWER_WAIT;
      r_reg.dp_s1  <= 1'b1;
      r_reg.dp_s2  <= 1'b1;
      r_reg.dp_q   <= 1'b1;
      r_reg.dm_s1  <= 1'b1;
      r_reg.dm_s2  <= 1'b1;
      r_reg.dm_q   <= 1'b1;
      r_reg.mask   <= `UPD_MASK_RST;
      r_reg.irq_en <= `UPD_CTRL_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs are flip-flop bits; the two open-drain pin values are tied low.
  assign rdata                   = r_reg.rdata;
  assign mode_usb                = r_reg.fsm[2];
  assign mode_ps2                = r_reg.ps2_on;
  assign usb_engine_enable       = r_reg.usb_on;
  assign usb_pullup_enable       = r_reg.usb_on;
  assign clock_pin_pullup_enable = r_reg.ps2_on;
  assign data_pin_pullup_enable  = r_reg.ps2_on;
  // The D+ pin is the PS2 clock and D- the PS2 data line.
  assign shared_clock_pin_out    = 1'b0;
  assign shared_data_pin_out     = 1'b0;
  assign shared_clock_pin_oe_n   = ~r_reg.ck_dir;
  assign shared_data_pin_oe_n    = ~r_reg.dt_dir;
  assign keyboard_pin_interrupt  = r_reg.irq;

  // Checks on the mode decision and line control.
  property p_power_wait;
    @(posedge sys_clk) disable iff (!reset_n)
    r_reg.fsm == ST_POWER_WAIT |-> !usb_engine_enable && !usb_pullup_enable;
  endproperty
  a_power_wait: assert property (p_power_wait)
    else $error("USB enabled during power-up wait");

  property p_usb_pick;
    @(posedge sys_clk) disable iff (!reset_n)
    r_reg.fsm == ST_DETECT && clk_en && setup_token_valid |=> mode_usb;
  endproperty
  a_usb_pick: assert property (p_usb_pick)
    else $error("SETUP token did not select USB");

  property p_ps2_pick;
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(mode_ps2) |-> $past(r_reg.dp_s2) && $past(r_reg.cnt) == SEL_LAST;
  endproperty
  a_ps2_pick: assert property (p_ps2_pick)
    else $error("PS2 chosen without a full high interval");

  property p_commit;
    @(posedge sys_clk) disable iff (!reset_n)
    (mode_usb |=> mode_usb) and (mode_ps2 |=> mode_ps2);
  endproperty
  a_commit: assert property (p_commit)
    else $error("Mode changed after decision");

  property p_ps2_lines;
    @(posedge sys_clk) disable iff (!reset_n)
    mode_ps2 |-> clock_pin_pullup_enable && data_pin_pullup_enable &&
                 !usb_pullup_enable && !shared_clock_pin_out;
  endproperty
  a_ps2_lines: assert property (p_ps2_lines)
    else $error("PS2 pin setup wrong");

  property p_irq_edge;
    @(posedge sys_clk) disable iff (!reset_n)
    clk_en && mode_ps2 && r_reg.irq_en && r_reg.dm_q && !r_reg.dm_s2
      |=> r_reg.stat[`UPD_EV_DFALL];
  endproperty
  a_irq_edge: assert property (p_irq_edge)
    else $error("Data falling edge not flagged");

  property p_tx_abort;
    @(posedge sys_clk) disable iff (!reset_n)
    clk_en && r_reg.fsm == ST_PS2_TX && !r_reg.ph && r_reg.cnt == HALF_LAST &&
      !r_reg.dp_s2 |=> r_reg.fsm == ST_PS2_IDLE && shared_data_pin_oe_n;
  endproperty
  a_tx_abort: assert property (p_tx_abort)
    else $error("Held clock did not abort transmit");

  property p_tx_parity;
    @(posedge sys_clk) disable iff (!reset_n)
    r_reg.fsm == ST_PS2_IDLE ##1 r_reg.fsm == ST_PS2_TX
      |-> (^r_reg.shf[9:1]) && !r_reg.shf[0] && r_reg.shf[10];
  endproperty
  a_tx_parity: assert property (p_tx_parity)
    else $error("Transmit frame parity or framing wrong");

  property p_frame_len;
    @(posedge sys_clk) disable iff (!reset_n)
    r_reg.fsm == ST_PS2_TX |-> r_reg.bitn < `UPD_FRAME_BITS;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("Transmit frame too long");

endmodule

// >>> upd_host_model.sv
// Purpose: Behavioural host on the far side of the shared pin pair.
// Assumes: Both lines carry host pull-ups, so a released line reads high.
// Notes:   Clock holds and frame bits come only from the bench.
`timescale 1ns/10ps
module upd_host_model (
  input  wire logic        sys_clk,
  input  wire logic        ck_oe_n,
  input  wire logic        dt_oe_n,
  input  wire logic        usb_act,
  input  wire logic        host_ck_low,
  input  wire logic        go,
  input  wire logic [10:0] frame,
  output logic             ck_line,
  output logic             dt_line,
  output logic [10:0]      rx_bits,
  output int               rx_cnt,
  output int               low_len
);
  logic        usb_ph;
  logic        ck_d;
  int          run;
  logic [10:0] tx_sh;

  // Bus traffic toggles D+ every 80 ns, far inside the stuffing limit.
  initial begin
    usb_ph = 1'b0;
    #13;
    forever #80 usb_ph = ~usb_ph;
  end

  // Wired-AND with pull-ups: any party pulling low wins.
  assign ck_line = ck_oe_n & ~host_ck_low & ~(usb_act & usb_ph);
  assign dt_line = dt_oe_n & tx_sh[0];

  // Start quiet, with the host's data line released.
  initial begin
    tx_sh = '1;
    ck_d = 1'b1;
    run = 0;
    rx_cnt = 0;
    low_len = 0;
    rx_bits = '0;
  end

  // Sample data at clock falls, time low phases, shift host bits out.
  always @(posedge sys_clk) begin
    ck_d <= ck_line;
    run <= ck_line ? 0 : run + 1;
    if (ck_d & ~ck_line) begin
      rx_bits <= {dt_line, rx_bits[10:1]};
      rx_cnt <= rx_cnt + 1;
      tx_sh <= {1'b1, tx_sh[10:1]};
    end
    if (~ck_d & ck_line) low_len <= run;
    if (go) tx_sh <= frame;
  end
endmodule

// >>> test_usb_ps2_detect_line_control.sv
// Purpose: Self-checking bench of pin-pair detection and PS2 line control.
// Assumes: Short counts keep the power wait and frame times small.
// Notes:   The register bus never stalls; every wait is bounded.
`timescale 1ns/10ps
`include "upd_params.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module test_usb_ps2_detect_line_control;
  localparam int PW = 200;
  localparam int SEL = 50;
  localparam int HALF = 8;
  logic        sys_clk, reset_n, wr, rd, setup_token_valid, clk_en;
  logic        usb_act, host_ck_low, go, ck_oe_n, dt_oe_n, ck_line, dt_line;
  logic        ck_out, dt_out, ck_pu, dt_pu, usb_pu, usb_en, m_usb, m_ps2, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v;
  logic [10:0] frame, rx_bits;
  int          failures, total_checks, rx_cnt, low_len;

  upd_line_ctrl #(.POWER_CYC(PW), .SEL_CYC(SEL), .HALF_CYC(HALF)) dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .setup_token_valid(setup_token_valid),
    .shared_clock_pin_in(ck_line), .shared_clock_pin_out(ck_out),
    .shared_clock_pin_oe_n(ck_oe_n), .shared_data_pin_in(dt_line),
    .shared_data_pin_out(dt_out), .shared_data_pin_oe_n(dt_oe_n),
    .clock_pin_pullup_enable(ck_pu), .data_pin_pullup_enable(dt_pu),
    .usb_pullup_enable(usb_pu), .usb_engine_enable(usb_en),
    .mode_usb(m_usb), .mode_ps2(m_ps2), .keyboard_pin_interrupt(irq));

  upd_host_model host_u (
    .sys_clk(sys_clk), .ck_oe_n(ck_oe_n), .dt_oe_n(dt_oe_n),
    .usb_act(usb_act), .host_ck_low(host_ck_low), .go(go), .frame(frame),
    .ck_line(ck_line), .dt_line(dt_line), .rx_bits(rx_bits),
    .rx_cnt(rx_cnt), .low_len(low_len));

  // Free-running 125 MHz clock.
  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;

  // Prints the counts and the verdict, then ends the run.
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Register bus cycles; read data is taken in the cycle after the strobe.
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Bounded waits; running out counts as a mismatch and ends the run.
  task wait_irq(input int lim);
    for (int i = 0; i < lim && irq !== 1'b1; i++) @(posedge sys_clk);
    if (irq !== 1'b1) begin
      failures++;
      report_and_stop;
    end
  endtask

  task wait_rx(input int want);
    for (int i = 0; i < 1000 && rx_cnt < want; i++) @(posedge sys_clk);
    if (rx_cnt < want) begin
      failures++;
      report_and_stop;
    end
  endtask

  task do_reset(input logic u);
    @(posedge sys_clk);
    usb_act <= u;
    reset_n <= 1'b0;
    tick(5);
    reset_n <= 1'b1;
  endtask

  task pulse_setup;
    @(posedge sys_clk);
    setup_token_valid <= 1'b1;
    @(posedge sys_clk);
    setup_token_valid <= 1'b0;
    tick(2);
  endtask

  task t_detect_usb;
    do_reset(1'b1);
    tick(PW - 10);
    `CHK(usb_en, 1'b0)
    rd_reg(`UPD_ADDR_STATUS);
    `CHK(v, 32'h1)
    tick(20);
    `CHK({usb_en, usb_pu, m_usb, m_ps2}, 4'hc)
    tick(3 * SEL);
    `CHK(m_ps2, 1'b0)
    pulse_setup;
    `CHK({m_usb, m_ps2, ck_pu, dt_pu}, 4'h8)
    usb_act <= 1'b0;
    tick(3 * SEL);
    `CHK({m_usb, m_ps2, usb_en}, 3'h5)
    $display("test usb detect done");
  endtask

  task t_detect_ps2;
    do_reset(1'b0);
    tick(PW + SEL - 8);
    `CHK(m_ps2, 1'b0)
    tick(20);
    `CHK({m_ps2, ck_pu, dt_pu, usb_pu, usb_en}, 5'h1c)
    `CHK({ck_out, dt_out, ck_oe_n, dt_oe_n}, 4'h3)
    pulse_setup;
    `CHK(m_usb, 1'b0)
    rd_reg(8'h1c);
    `CHK(v, 32'h0)
    $display("test ps2 detect done");
  endtask

  // A write while the clock enable is low is lost and no line moves.
  task t_freeze;
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr_reg(`UPD_ADDR_TXDATA, 32'h42);
    tick(20);
    `CHK({ck_oe_n, dt_oe_n, m_ps2}, 3'h7)
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd_reg(`UPD_ADDR_TXDATA);
    `CHK(v[8:0], 9'h000)
    $display("test clock enable freeze done");
  endtask

  // Three bytes back to back, then the masked and unmasked interrupt.
  task t_tx;
    logic [7:0] bt [3];
    int base;
    bt = '{8'ha5, 8'h00, 8'h80};
    wr_reg(`UPD_ADDR_IRQMSK, 32'h0);
    foreach (bt[k]) begin
      base = rx_cnt;
      wr_reg(`UPD_ADDR_TXDATA, {24'h0, bt[k]});
      wait_rx(base + 11);
      `CHK(rx_bits, {1'b1, ~^bt[k], bt[k], 1'b0})
      tick(4 * HALF);
      `CHK(low_len, HALF)
      `CHK({ck_oe_n, dt_oe_n, ck_out, dt_out}, 4'hc)
    end
    rd_reg(`UPD_ADDR_IRQST);
    `CHK({v[1], irq}, 2'h2)
    wr_reg(`UPD_ADDR_IRQMSK, 32'h2);
    tick(2);
    `CHK(irq, 1'b1)
    rd_reg(`UPD_ADDR_IRQMSK);
    `CHK(v, 32'h2)
    wr_reg(`UPD_ADDR_IRQST, 32'h1f);
    tick(2);
    `CHK(irq, 1'b0)
    $display("test ps2 send done");
  endtask

  task t_abort;
    int base;
    wr_reg(`UPD_ADDR_IRQMSK, 32'h8);
    base = rx_cnt;
    wr_reg(`UPD_ADDR_TXDATA, 32'h3c);
    wait_rx(base + 3);
    host_ck_low <= 1'b1;
    wait_irq(200);
    tick(2);
    `CHK({ck_oe_n, dt_oe_n}, 2'h3)
    host_ck_low <= 1'b0;
    tick(300);
    wr_reg(`UPD_ADDR_IRQST, 32'h1f);
    tick(2);
    `CHK(irq, 1'b0)
    $display("test ps2 abort done");
  endtask

  // A good frame with the fall interrupt on, then bad parity with it off.
  task t_rx;
    logic [7:0] d;
    d = 8'h5b;
    wr_reg(`UPD_ADDR_IRQMSK, 32'h4);
    for (int k = 0; k < 2; k++) begin
      wr_reg(`UPD_ADDR_CTRL, {31'h0, ~k[0]});
      @(posedge sys_clk);
      frame <= {1'b1, ~^d ^ k[0], d, 1'b0};
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      wait_irq(1000);
      rd_reg(`UPD_ADDR_RXDATA);
      `CHK(v[8:0], {k[0], d})
      rd_reg(`UPD_ADDR_IRQST);
      `CHK(v[0], ~k[0])
      wr_reg(`UPD_ADDR_IRQST, 32'h1f);
      tick(4 * HALF);
      `CHK(irq, 1'b0)
    end
    $display("test ps2 receive done");
  endtask

  // Main sequence.
  initial begin
    reset_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    setup_token_valid = 1'b0;
    clk_en = 1'b1;
    usb_act = 1'b1;
    host_ck_low = 1'b0;
    go = 1'b0;
    frame = '1;
    failures = 0;
    total_checks = 0;
    t_detect_usb;
    t_detect_ps2;
    t_freeze;
    t_tx;
    t_abort;
    t_rx;
    report_and_stop;
  end
endmodule
